// file: inc/dma_pkg.sv
package dma_pkg;
	// ==========================================================
	// timing
	localparam int CLK_HZ = 40_000_000; // system clock rate
	localparam int SEC_NS = 1_000_000_000; // one second in ns
	localparam int CLK_NS = 25; // clock period in ns
	localparam int CYC_PER_SEC = SEC_NS / CLK_NS; // timebase count
	localparam int SEC_PER_MIN = 60; // seconds in a minute
	localparam int MIN_PER_HOUR = 60; // minutes in an hour
	localparam int HOUR_PER_DAY = 24; // 24 x 60 = 1440 minutes a day
	localparam int HIST_DEPTH = 60; // longest interval, in minutes
	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00; // latch reset command
	localparam logic [7:0] OFS_CFG0 = 8'h04; // cfg: current, real, react, app
	localparam logic [7:0] OFS_THR0 = 8'h14; // thresholds, same order
	localparam logic [7:0] OFS_TOD = 8'h24; // time of day
	localparam logic [7:0] OFS_IRQ_STAT = 8'h28; // sticky events, w1c
	localparam logic [7:0] OFS_IRQ_MASK = 8'h2c; // event enables
	localparam logic [7:0] OFS_DEM0 = 8'h30; // demand a, b, c, w, var, va
	localparam logic [7:0] OFS_STAT = 8'h48; // alarm and relay state
	// ==========================================================
	// field positions and resets
	localparam int CFG_FUNC_LSB = 0; // 2 bits response select
	localparam int CFG_METH_LSB = 2; // 2 bits method
	localparam int CFG_THERM_LSB = 4; // 3 bits response time index
	localparam int CFG_INTV_LSB = 8; // 3 bits interval index
	localparam int CFG_RLY_LSB = 16; // 5 bits, relays 3..7
	localparam int TOD_HOUR_LSB = 8; // hour field, minute in [5:0]
	localparam logic [2:0] IDX_MAX = 3'h5; // six choices 0..5
	localparam logic [2:0] THERM_RST = 3'h2; // 15 min
	localparam logic [2:0] INTV_RST = 3'h3; // 20 min
	localparam logic [14:0] THR_MIN = 15'h0001; // 0.1 in 0.1 units
	localparam logic [14:0] THR_MAX = 15'h7530; // 3000.0 in 0.1 units
	localparam logic [14:0] THR_RST = 15'h0064; // 10.0 in 0.1 units
	// ==========================================================
	// modes
	typedef enum logic [1:0] {FN_DISABLED, FN_ALARM, FN_LATCHED, FN_CONTROL}
		dma_func_t;
	typedef enum logic [1:0] {MT_THERMAL, MT_BLOCK, MT_ROLLING, MT_SPARE}
		dma_meth_t;
	// interval length in minutes for a choice index
	function automatic logic [6:0] minutes(input logic [2:0] idx);
		case (idx)
			3'h0: minutes = 7'h05;
			3'h1: minutes = 7'h0a;
			3'h2: minutes = 7'h0f;
			3'h3: minutes = 7'h14;
			3'h4: minutes = 7'h1e;
			default: minutes = 7'h3c;
		endcase
	endfunction
	// 65536 / minutes, rounded up
	function automatic logic [15:0] recip(input logic [2:0] idx);
		case (idx)
			3'h0: recip = 16'h3334;
			3'h1: recip = 16'h199a;
			3'h2: recip = 16'h1112;
			3'h3: recip = 16'h0ccd;
			3'h4: recip = 16'h0889;
			default: recip = 16'h0445;
		endcase
	endfunction
	// per second step, 65536 * (1 - exp(-2.3 / (60 * minutes)))
	function automatic logic [15:0] therm_coef(input logic [2:0] idx);
		case (idx)
			3'h0: therm_coef = 16'h01f5;
			3'h1: therm_coef = 16'h00fb;
			3'h2: therm_coef = 16'h00a7;
			3'h3: therm_coef = 16'h007d;
			3'h4: therm_coef = 16'h0054;
			default: therm_coef = 16'h002a;
		endcase
	endfunction
endpackage

// file: logic/dma_demand_calc.sv
module dma_demand_calc #(
	parameter int DW = 16
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// measurement and time
	input wire logic [DW-1:0] i_sample,
	input wire logic i_tick_sec,
	input wire logic i_tick_min,
	input wire logic i_block_end,
	// settings
	input wire logic [1:0] i_meth,
	input wire logic [2:0] i_therm,
	input wire logic [2:0] i_intv,
	// result
	output logic [DW-1:0] o_demand
);
	// ==========================================================
	// thermal filter, 16 fraction bits so small steps never stall
	localparam int AW = DW + 16;
	logic [AW-1:0] acc_q;
	logic signed [AW+1:0] diff;
	logic signed [AW+18:0] prod;
	logic signed [AW+1:0] acc_d;
	always_comb
	begin
		diff = $signed({2'b00, i_sample, 16'h0000}) - $signed({2'b00, acc_q});
		prod = diff * $signed({1'b0, dma_pkg::therm_coef(i_therm)});
		acc_d = $signed({2'b00, acc_q}) + prod[AW+17:16];
	end
	// held sample stepped once a second
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			acc_q <= '0;
		else if (i_tick_sec)
			acc_q <= acc_d[AW-1:0];
	end
	// ==========================================================
	// minute average of sixty one second samples
	logic [DW+5:0] sec_sum_q;
	logic [DW+5:0] min_tot;
	logic [DW+22:0] min_prod;
	logic [DW-1:0] min_avg;
	always_comb
	begin
		min_tot = sec_sum_q + (DW+6)'(i_sample);
		min_prod = min_tot * 17'h00445;
		min_avg = min_prod[DW+22:16] > (DW+7)'({DW{1'b1}}) ? {DW{1'b1}}
			: min_prod[DW+15:16];
	end
	// the closing sample of a minute rides on the minute tick
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			sec_sum_q <= '0;
		else if (i_tick_min)
			sec_sum_q <= '0;
		else if (i_tick_sec)
			sec_sum_q <= min_tot;
	end
	// ==========================================================
	// minute history, running sums, published averages
	logic [DW-1:0] hist_q [0:dma_pkg::HIST_DEPTH-1];
	logic [5:0] wp_q;
	logic [6:0] fill_q;
	logic [DW+5:0] roll_q;
	logic [DW+5:0] blk_q;
	logic [DW-1:0] dem_q;
	logic [4:0] cfg_q;
	logic [6:0] n_min;
	logic [5:0] rd;
	logic [DW+5:0] roll_d;
	logic [DW+22:0] avg_prod;
	logic [DW+5:0] avg_src;
	always_comb
	begin
		n_min = dma_pkg::minutes(i_intv);
		rd = (7'(wp_q) >= n_min) ? 6'(7'(wp_q) - n_min)
			: 6'(7'(wp_q) + 7'd60 - n_min);
		roll_d = roll_q + (DW+6)'(min_avg)
			- ((fill_q >= n_min) ? (DW+6)'(hist_q[rd]) : '0);
		avg_src = (i_meth == dma_pkg::MT_ROLLING) ? roll_d
			: blk_q + (DW+6)'(min_avg);
		avg_prod = avg_src * {1'b0, dma_pkg::recip(i_intv)};
	end
	// a method or interval change restarts the averages from empty
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			wp_q <= '0;
			fill_q <= '0;
			roll_q <= '0;
			blk_q <= '0;
			dem_q <= '0;
			cfg_q <= '0;
		end
		else if (cfg_q != {i_meth, i_intv})
		begin
			cfg_q <= {i_meth, i_intv};
			fill_q <= '0;
			roll_q <= '0;
			blk_q <= '0;
		end
		else if (i_meth == dma_pkg::MT_THERMAL)
			dem_q <= acc_q[AW-1:16];
		else if (i_tick_min)
		begin
			wp_q <= (wp_q == 6'd59) ? '0 : wp_q + 6'd1;
			// rolling: refreshed every minute over the last n
			if (i_meth == dma_pkg::MT_ROLLING)
			begin
				roll_q <= roll_d;
				fill_q <= (fill_q >= n_min) ? n_min : fill_q + 7'd1;
				if (fill_q + 7'd1 >= n_min)
					dem_q <= avg_prod[DW+15:16];
			end
			// block: published only at an aligned end
			else if (i_block_end)
			begin
				blk_q <= '0;
				dem_q <= avg_prod[DW+15:16];
			end
			else
				blk_q <= blk_q + (DW+6)'(min_avg);
		end
	end
	// history kept as flip-flops, written at the minute pointer
	always_ff @(posedge i_clk)
	begin
		if (i_tick_min)
			hist_q[wp_q] <= min_avg;
	end
	assign o_demand = dem_q;
endmodule

// file: logic/dma_response.sv
module dma_response #(
	parameter int N = 1
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// comparison and settings
	input wire logic [N-1:0] i_over,
	input wire logic [1:0] i_func,
	input wire logic [4:0] i_relays,
	input wire logic i_latch_clr,
	// response
	output logic o_alarm,
	output logic o_latched,
	output logic [4:0] o_relays
);
	logic any_over;
	assign any_over = |i_over; // any phase is enough
	// plain alarm follows the comparison; disabled stays quiet
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_alarm <= 1'b0;
		else
			o_alarm <= any_over && i_func == dma_pkg::FN_ALARM;
	end
	// latched alarm holds until reset; a new pickup beats the clear
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_latched <= 1'b0;
		else if (i_func != dma_pkg::FN_LATCHED)
			o_latched <= 1'b0;
		else if (any_over)
			o_latched <= 1'b1;
		else if (i_latch_clr)
			o_latched <= 1'b0;
	end
	// control drives the chosen relays 3..7
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_relays <= '0;
		else if (any_over && i_func == dma_pkg::FN_CONTROL)
			o_relays <= i_relays;
		else
			o_relays <= '0;
	end
endmodule

// file: logic/dma_top.sv
// Overview of operation
// - per phase current demand, one shared threshold
// - any phase over threshold raises response
// - each power demand has own threshold
// - response: disabled, alarm, latched alarm, control
// - method: thermal, block or rolling; block default
// - response time 5..60 min choices, default 15
// - response time reaches ninety percent of input
// - interval default 20 min, same six choices
// - real threshold 0.1..3000.0, 0.1 steps, default 10.0
// - apparent threshold 0.1..3000.0, default 10.0
// - relay mask picks any of relays 3..7
// - thermal: sample each second, exponential step
// - block intervals aligned to midnight, published at end
// - rolling average refreshed each minute
//
// The AXI4-Lite register port and the register offsets were left to the implementer.
module dma_top #(
	parameter int DW = 16,
	parameter int CYC_PER_SEC = dma_pkg::CYC_PER_SEC
) (
	// clock and reset
	input wire logic I_CLK,
	input wire logic I_RST_N,
	// measurements: phase a, b, c current; real, reactive, apparent
	input wire logic [DW-1:0] I_MEAS_IA,
	input wire logic [DW-1:0] I_MEAS_IB,
	input wire logic [DW-1:0] I_MEAS_IC,
	input wire logic [DW-1:0] I_MEAS_W,
	input wire logic [DW-1:0] I_MEAS_VAR,
	input wire logic [DW-1:0] I_MEAS_VA,
	// axi4-lite write address
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	input wire logic [7:0] I_AWADDR,
	// axi4-lite write data
	input wire logic I_WVALID,
	output logic O_WREADY,
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	// axi4-lite write response
	output logic O_BVALID,
	input wire logic I_BREADY,
	output logic [1:0] O_BRESP,
	// axi4-lite read address
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	input wire logic [7:0] I_ARADDR,
	// axi4-lite read data
	output logic O_RVALID,
	input wire logic I_RREADY,
	output logic [31:0] O_RDATA,
	output logic [1:0] O_RRESP,
	// annunciation and relays
	output logic O_ALARM,
	output logic O_LATCHED_ALARM,
	output logic [4:0] O_AUX_RELAY,
	output logic O_IRQ
);
	localparam int NG = 4; // groups: current, real, reactive, apparent
	localparam int NQ = 6; // quantities
	// ==========================================================
	// timebase: seconds, minutes, time of day
	logic [31:0] cyc_q; // cycles inside the current second
	logic [5:0] sec_q; // seconds inside the minute
	logic [5:0] min_q; // minute of the hour
	logic [4:0] hour_q; // hour of the day
	logic tick_sec; // one cycle per second
	logic tick_min; // one cycle per minute
	logic tod_wr; // software loads the time of day
	logic [31:0] wdata_q; // accepted write data
	assign tick_sec = cyc_q == 32'(CYC_PER_SEC - 1);
	assign tick_min = tick_sec && sec_q == 6'(dma_pkg::SEC_PER_MIN - 1);
	// cycle counter, wraps every second
	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			cyc_q <= '0;
		else if (tick_sec)
			cyc_q <= '0;
		else
			cyc_q <= cyc_q + 32'd1;
	end
	// clock of the day; a load also restarts the minute
	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			sec_q <= '0;
			min_q <= '0;
			hour_q <= '0;
		end
		else if (tod_wr)
		begin
			sec_q <= '0;
			min_q <= wdata_q[5:0];
			hour_q <= wdata_q[dma_pkg::TOD_HOUR_LSB +: 5];
		end
		else if (tick_min)
		begin
			sec_q <= '0;
			if (min_q == 6'(dma_pkg::MIN_PER_HOUR - 1))
			begin
				min_q <= '0;
				// day rolls over at midnight
				if (hour_q == 5'(dma_pkg::HOUR_PER_DAY - 1))
					hour_q <= '0;
				else
					hour_q <= hour_q + 5'd1;
			end
			else
				min_q <= min_q + 6'd1;
		end
		else if (tick_sec)
			sec_q <= sec_q + 6'd1;
	end
	// ==========================================================
	// settings
	logic [31:0] cfg_q [0:NG-1]; // per group configuration
	logic [14:0] thr_q [0:NG-1]; // per group threshold
	logic [NG-1:0] irq_mask_q; // interrupt enables
	logic [NG-1:0] irq_stat_q; // sticky pickup events
	logic latch_clr_q; // one cycle reset of latched alarms
	logic cfg_wr; // write to a configuration word
	logic thr_wr; // write to a threshold word
	logic [1:0] wsel; // group addressed by the write
	logic [7:0] awaddr_q; // accepted write address
	logic [3:0] wstrb_q; // accepted byte enables
	// keep a threshold inside its legal span
	function automatic logic [14:0] clamp(input logic [31:0] v);
		if (v[31:15] != '0 || v[14:0] > dma_pkg::THR_MAX)
			clamp = dma_pkg::THR_MAX;
		else if (v[14:0] < dma_pkg::THR_MIN)
			clamp = dma_pkg::THR_MIN;
		else
			clamp = v[14:0];
	endfunction
	// an out of range choice index keeps the previous one
	function automatic logic [2:0] pick(input logic [2:0] n,
		input logic [2:0] o);
		pick = (n > dma_pkg::IDX_MAX) ? o : n;
	endfunction
	// configuration words; fields written as a whole word
	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			for (int g = 0; g < NG; g++)
			begin
				// disabled, block method default
				cfg_q[g] <= '0;
				cfg_q[g][dma_pkg::CFG_METH_LSB +: 2] <= dma_pkg::MT_BLOCK;
				cfg_q[g][dma_pkg::CFG_THERM_LSB +: 3] <= dma_pkg::THERM_RST;
				cfg_q[g][dma_pkg::CFG_INTV_LSB +: 3] <= dma_pkg::INTV_RST;
			end
		end
		else if (cfg_wr && wstrb_q == 4'hf)
		begin
			cfg_q[wsel] <= '0;
			cfg_q[wsel][dma_pkg::CFG_FUNC_LSB +: 2] <=
				wdata_q[dma_pkg::CFG_FUNC_LSB +: 2];
			cfg_q[wsel][dma_pkg::CFG_METH_LSB +: 2] <=
				(wdata_q[dma_pkg::CFG_METH_LSB +: 2] == dma_pkg::MT_SPARE)
				? cfg_q[wsel][dma_pkg::CFG_METH_LSB +: 2]
				: wdata_q[dma_pkg::CFG_METH_LSB +: 2];
			cfg_q[wsel][dma_pkg::CFG_THERM_LSB +: 3] <=
				pick(wdata_q[dma_pkg::CFG_THERM_LSB +: 3],
				cfg_q[wsel][dma_pkg::CFG_THERM_LSB +: 3]);
			cfg_q[wsel][dma_pkg::CFG_INTV_LSB +: 3] <=
				pick(wdata_q[dma_pkg::CFG_INTV_LSB +: 3],
				cfg_q[wsel][dma_pkg::CFG_INTV_LSB +: 3]);
			cfg_q[wsel][dma_pkg::CFG_RLY_LSB +: 5] <=
				wdata_q[dma_pkg::CFG_RLY_LSB +: 5];
		end
	end
	// thresholds, 0.1 unit steps, clamped on write
	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			for (int g = 0; g < NG; g++)
				thr_q[g] <= dma_pkg::THR_RST;
		end
		else if (thr_wr && wstrb_q == 4'hf)
			thr_q[wsel] <= clamp(wdata_q);
	end
	// ==========================================================
	// demand elements, one per quantity
	logic [DW-1:0] meas [0:NQ-1]; // quantity inputs
	logic [DW-1:0] dem [0:NQ-1]; // demand results
	logic [NQ-1:0] over; // demand above its threshold
	logic [NQ-1:0] blk_end; // aligned end of a block interval
	logic [1:0] grp [0:NQ-1]; // group that owns each quantity
	assign meas[0] = I_MEAS_IA;
	assign meas[1] = I_MEAS_IB;
	assign meas[2] = I_MEAS_IC;
	assign meas[3] = I_MEAS_W;
	assign meas[4] = I_MEAS_VAR;
	assign meas[5] = I_MEAS_VA;
	for (genvar q = 0; q < NQ; q++)
	begin : g_q
		// the three phases share the current settings
		assign grp[q] = (q < 3) ? 2'd0 : 2'(q - 2);
		// intervals divide the hour, so minute zero of a day aligns
		assign blk_end[q] = (min_q + 6'd1 == 6'd60) || (7'(min_q + 6'd1)
			% dma_pkg::minutes(cfg_q[grp[q]][dma_pkg::CFG_INTV_LSB +: 3])
			== 7'd0);
		// strictly above the threshold counts
		assign over[q] = dem[q] > DW'(thr_q[grp[q]]);
		dma_demand_calc #(
			.DW(DW)
		) u_calc (
			.i_clk(I_CLK),
			.i_rst_n(I_RST_N),
			.i_sample(meas[q]),
			.i_tick_sec(tick_sec),
			.i_tick_min(tick_min),
			.i_block_end(blk_end[q]),
			.i_meth(cfg_q[grp[q]][dma_pkg::CFG_METH_LSB +: 2]),
			.i_therm(cfg_q[grp[q]][dma_pkg::CFG_THERM_LSB +: 3]),
			.i_intv(cfg_q[grp[q]][dma_pkg::CFG_INTV_LSB +: 3]),
			.o_demand(dem[q])
		);
	end
	// ==========================================================
	// responses, one per group
	logic [NG-1:0] alarm; // plain alarms
	logic [NG-1:0] latched; // latched alarms
	logic [4:0] rly [0:NG-1]; // relay requests
	logic [2:0] gover [0:NG-1]; // comparison inputs per group
	assign gover[0] = over[2:0];
	assign gover[1] = {2'b00, over[3]};
	assign gover[2] = {2'b00, over[4]};
	assign gover[3] = {2'b00, over[5]};
	for (genvar g = 0; g < NG; g++)
	begin : g_g
		dma_response #(
			.N(3)
		) u_resp (
			.i_clk(I_CLK),
			.i_rst_n(I_RST_N),
			.i_over(gover[g]),
			.i_func(cfg_q[g][dma_pkg::CFG_FUNC_LSB +: 2]),
			.i_relays(cfg_q[g][dma_pkg::CFG_RLY_LSB +: 5]),
			.i_latch_clr(latch_clr_q),
			.o_alarm(alarm[g]),
			.o_latched(latched[g]),
			.o_relays(rly[g])
		);
	end
	assign O_ALARM = |alarm;
	assign O_LATCHED_ALARM = |latched;
	assign O_AUX_RELAY = rly[0] | rly[1] | rly[2] | rly[3];
	// ==========================================================
	// interrupts: rising alarm, latched alarm or relay drive per group
	logic [NG-1:0] act; // group is acting
	logic [NG-1:0] act_q; // previous value
	logic stat_wr; // write one to clear
	assign act = alarm | latched | {rly[3] != '0, rly[2] != '0,
		rly[1] != '0, rly[0] != '0};
	// a new event wins over a clear in the same cycle
	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			act_q <= '0;
			irq_stat_q <= '0;
		end
		else
		begin
			act_q <= act;
			irq_stat_q <= (irq_stat_q & ~(stat_wr ? wdata_q[NG-1:0] : '0))
				| (act & ~act_q);
		end
	end
	assign O_IRQ = |(irq_stat_q & irq_mask_q);
	// ==========================================================
	// axi4-lite write channel
	logic aw_full_q; // address held
	logic w_full_q; // data held
	logic wr_go; // both halves present, response free
	assign O_AWREADY = !aw_full_q;
	assign O_WREADY = !w_full_q;
	assign wr_go = aw_full_q && w_full_q && !O_BVALID;
	assign wsel = 2'((awaddr_q - dma_pkg::OFS_CFG0) >> 2);
	assign cfg_wr = wr_go && awaddr_q >= dma_pkg::OFS_CFG0
		&& awaddr_q < dma_pkg::OFS_THR0;
	assign thr_wr = wr_go && awaddr_q >= dma_pkg::OFS_THR0
		&& awaddr_q < dma_pkg::OFS_TOD;
	assign tod_wr = wr_go && awaddr_q == dma_pkg::OFS_TOD;
	assign stat_wr = wr_go && awaddr_q == dma_pkg::OFS_IRQ_STAT;
	// address and data taken in either order
	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			O_BVALID <= 1'b0;
			O_BRESP <= 2'b00;
		end
		else
		begin
			if (I_AWVALID && O_AWREADY)
			begin
				aw_full_q <= 1'b1;
				awaddr_q <= {I_AWADDR[7:2], 2'b00};
			end
			if (I_WVALID && O_WREADY)
			begin
				w_full_q <= 1'b1;
				wdata_q <= I_WDATA;
				wstrb_q <= I_WSTRB;
			end
			if (wr_go)
			begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				O_BVALID <= 1'b1;
				// unmapped or read-only words answer slverr
				O_BRESP <= (awaddr_q < dma_pkg::OFS_DEM0) ? 2'b00 : 2'b10;
			end
			else if (O_BVALID && I_BREADY)
				O_BVALID <= 1'b0;
		end
	end
	// control pulses and the mask register
	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			latch_clr_q <= 1'b0;
			irq_mask_q <= '0;
		end
		else
		begin
			// bit 0 of the control word resets latched alarms
			latch_clr_q <= wr_go && awaddr_q == dma_pkg::OFS_CTRL
				&& wdata_q[0];
			if (wr_go && awaddr_q == dma_pkg::OFS_IRQ_MASK)
				irq_mask_q <= wdata_q[NG-1:0];
		end
	end
	// ==========================================================
	// axi4-lite read channel
	logic [31:0] rd_word; // decoded read value
	logic rd_ok; // address is mapped
	logic [7:0] ra; // word aligned read address
	always_comb
	begin
		ra = {I_ARADDR[7:2], 2'b00};
		rd_word = '0;
		rd_ok = 1'b1;
		if (ra >= dma_pkg::OFS_CFG0 && ra < dma_pkg::OFS_THR0)
			rd_word = cfg_q[2'((ra - dma_pkg::OFS_CFG0) >> 2)];
		else if (ra >= dma_pkg::OFS_THR0 && ra < dma_pkg::OFS_TOD)
			rd_word = 32'(thr_q[2'((ra - dma_pkg::OFS_THR0) >> 2)]);
		else if (ra >= dma_pkg::OFS_DEM0 && ra < dma_pkg::OFS_STAT)
			rd_word = 32'(dem[3'((ra - dma_pkg::OFS_DEM0) >> 2)]);
		else
		begin
			case (ra)
				dma_pkg::OFS_CTRL: rd_word = '0;
				dma_pkg::OFS_TOD: rd_word = {19'h0, hour_q, 2'b00, min_q};
				dma_pkg::OFS_IRQ_STAT: rd_word = 32'(irq_stat_q);
				dma_pkg::OFS_IRQ_MASK: rd_word = 32'(irq_mask_q);
				dma_pkg::OFS_STAT: rd_word = {15'h0, O_AUX_RELAY,
					latched, alarm, 4'(irq_stat_q)};
				default: rd_ok = 1'b0;
			endcase
		end
	end
	assign O_ARREADY = !O_RVALID;
	// one read at a time; data held until taken
	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			O_RVALID <= 1'b0;
			O_RDATA <= '0;
			O_RRESP <= 2'b00;
		end
		else if (I_ARVALID && O_ARREADY)
		begin
			O_RVALID <= 1'b1;
			O_RDATA <= rd_word;
			O_RRESP <= rd_ok ? 2'b00 : 2'b10;
		end
		else if (O_RVALID && I_RREADY)
			O_RVALID <= 1'b0;
	end
endmodule

// file: verif/dma_top_assertions.sv
module dma_top_assertions (
	// watched ports
	input wire logic I_CLK,
	input wire logic I_RST_N,
	input wire logic I_AWVALID,
	input wire logic O_AWREADY,
	input wire logic I_BREADY,
	input wire logic O_BVALID,
	input wire logic I_ARVALID,
	input wire logic O_ARREADY,
	input wire logic I_RREADY,
	input wire logic O_RVALID,
	input wire logic [31:0] O_RDATA,
	input wire logic [1:0] O_RRESP,
	input wire logic O_LATCHED_ALARM,
	input wire logic [4:0] O_AUX_RELAY
);
	// ==========
	// bus handshakes and response outputs
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);
	a_read_ready_rule: assert property (O_ARREADY == !O_RVALID)
		else $error("read ready not inverse of valid");
	a_read_answer: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
		else $error("read answer late");
	a_rdata_holds: assert property
		(O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
		else $error("read data dropped");
	a_bvalid_holds: assert property (O_BVALID && !I_BREADY |=> O_BVALID)
		else $error("write response dropped");
	a_addr_held: assert property (I_AWVALID && O_AWREADY |=> !O_AWREADY)
		else $error("address slot not held");
	a_resp_codes: assert property
		(O_RVALID |-> O_RRESP == 2'h0 || O_RRESP == 2'h2)
		else $error("bad read response code");
	a_unmapped_zero: assert property
		(O_RVALID && O_RRESP == 2'h2 |-> O_RDATA == 32'h0)
		else $error("error read carries data");
	// a latch may only drop around a write response
	a_latch_holds: assert property (O_LATCHED_ALARM |=> O_LATCHED_ALARM ||
		O_BVALID || $past(O_BVALID) || $past(O_BVALID, 2))
		else $error("latched alarm dropped");
	a_reset_quiet: assert property
		($rose(I_RST_N) |-> O_AUX_RELAY == 5'h00 && !O_LATCHED_ALARM)
		else $error("outputs active after reset");
endmodule
bind dma_top dma_top_assertions u_chk (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
	.I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY), .I_BREADY(I_BREADY),
	.O_BVALID(O_BVALID), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY),
	.I_RREADY(I_RREADY), .O_RVALID(O_RVALID), .O_RDATA(O_RDATA),
	.O_RRESP(O_RRESP), .O_LATCHED_ALARM(O_LATCHED_ALARM),
	.O_AUX_RELAY(O_AUX_RELAY));

// file: verif/dma_relay_model.sv
module dma_relay_model (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// coil drive from the block
	input wire logic [4:0] i_energize,
	input wire logic i_alarm,
	// contact and lamp state
	output logic [4:0] o_contact,
	output logic o_lamp
);
	// ==========
	// contacts follow coils a cycle late; real relays are far slower
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_contact <= 5'h00;
		else
			o_contact <= i_energize;
	end
	// lamp follows the alarm line
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_lamp <= 1'b0;
		else
			o_lamp <= i_alarm;
	end
endmodule

// file: verif/demand_monitor_alarm_tb.sv
module demand_monitor_alarm_tb;
	timeunit 1ns;
	timeprecision 100ps;
	// ==========
	// signals
	logic I_CLK, I_RST_N, awv, wv, bry, arv, rry, awr, wrdy, bv, arr, rv;
	logic lat, alm, irq;
	logic [15:0] ia, ib, ic;
	logic [7:0] awa, ara;
	logic [31:0] wd, rdat, w;
	logic [1:0] br, rr;
	logic [4:0] rly, cont, msk;
	logic [33:0] exp_q[$];
	int bad_count, num_checks, n;
	// short second keeps the run small
	dma_top #(.CYC_PER_SEC(20)) dut (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
		.I_MEAS_IA(ia), .I_MEAS_IB(ib), .I_MEAS_IC(ic), .I_MEAS_W(ia),
		.I_MEAS_VAR(ib), .I_MEAS_VA(ic), .I_AWVALID(awv), .O_AWREADY(awr),
		.I_AWADDR(awa), .I_WVALID(wv), .O_WREADY(wrdy), .I_WDATA(wd),
		.I_WSTRB(4'hf), .O_BVALID(bv), .I_BREADY(bry), .O_BRESP(br),
		.I_ARVALID(arv), .O_ARREADY(arr), .I_ARADDR(ara), .O_RVALID(rv),
		.I_RREADY(rry), .O_RDATA(rdat), .O_RRESP(rr), .O_ALARM(alm),
		.O_LATCHED_ALARM(lat), .O_AUX_RELAY(rly), .O_IRQ(irq));
	dma_relay_model model (.i_clk(I_CLK), .i_rst_n(I_RST_N),
		.i_energize(rly), .i_alarm(alm), .o_contact(cont), .o_lamp());
	// ==========
	// helpers
	task check(input logic [33:0] got, input logic [33:0] exp);
		num_checks++;
		if (got !== exp)
			begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
			end
	endtask
	task tally_and_finish;
		if (bad_count == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task give_up;
		bad_count++;
		tally_and_finish();
	endtask
	// write: both halves offered together, each released when taken
	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge I_CLK);
		awv <= 1'b1;
		awa <= a;
		wv <= 1'b1;
		wd <= d;
		bry <= 1'b1;
		for (n = 0; n < 40 && !(bv && bry); n++)
		begin
			@(posedge I_CLK);
			if (awv && awr) awv <= 1'b0;
			if (wv && wrdy) wv <= 1'b0;
		end
		bry <= 1'b0;
		if (n == 40) give_up();
	endtask
	// read: expectation queued, compared by the monitor
	task rd_reg(input logic [7:0] a, input logic [33:0] e);
		@(posedge I_CLK);
		arv <= 1'b1;
		ara <= a;
		rry <= 1'b1;
		exp_q.push_back(e);
		for (n = 0; n < 40 && !(rv && rry); n++)
		begin
			@(posedge I_CLK);
			if (arv && arr) arv <= 1'b0;
		end
		rry <= 1'b0;
		if (n == 40) give_up();
	endtask
	// monitor takes the oldest note at each read answer
	always @(posedge I_CLK)
		if (rv && rry && exp_q.size() > 0) check({rr, rdat}, exp_q.pop_front());
	initial
	begin
		I_CLK = 1'b0;
		forever #12.5 I_CLK = ~I_CLK;
	end
	// ==========
	// main sequence
	initial
	begin
		{I_RST_N, awv, wv, bry, arv, rry} = 6'h00;
		{ia, ib, ic, awa, ara, wd} = '0;
		void'($urandom(63));
		msk = 5'(1 + $urandom % 31);
		repeat (16) @(posedge I_CLK);
		I_RST_N <= 1'b1;
		rd_reg(8'h04, 34'h324);
		rd_reg(8'h18, 34'h64);
		rd_reg(8'h20, 34'h64);
		wr_reg(8'h18, 32'h0);
		rd_reg(8'h18, 34'h1);
		wr_reg(8'h20, 32'h7fff);
		rd_reg(8'h20, 34'h7530);
		rd_reg(8'h4c, 34'h200000000);
		// every response, method and time choice read back
		for (int i = 0; i < 6; i++)
		begin
			w = 32'((i << 8) | (i << 4) | ((i % 3) << 2) | (i % 4));
			wr_reg(8'h08, w);
			rd_reg(8'h08, 34'(w));
		end
		// one phase over the shared threshold drives the relays
		wr_reg(8'h2c, 32'h1);
		wr_reg(8'h14, 32'd50);
		ia <= 16'd50;
		ib <= 16'($urandom % 50);
		ic <= 16'(51 + $urandom % 500);
		wr_reg(8'h04, {11'h0, msk, 16'h0007});
		for (n = 0; n < 30000 && cont !== msk; n++) @(posedge I_CLK);
		if (n == 30000) give_up();
		check(34'(irq), 34'h1);
		rd_reg(8'h48, 34'({msk, 12'h001}));
		wr_reg(8'h28, 32'h1);
		check(34'(irq), 34'h0);
		// disabled element never acts
		wr_reg(8'h04, {11'h0, msk, 16'h0004});
		rd_reg(8'h48, 34'h0);
		// latched alarm: a reset command loses to a standing pickup
		wr_reg(8'h04, {11'h0, msk, 16'h0006});
		@(posedge I_CLK);
		check(34'(lat), 34'h1);
		wr_reg(8'h00, 32'h1);
		@(posedge I_CLK);
		check(34'(lat), 34'h1);
		// plain alarm follows the comparison, latch released
		wr_reg(8'h04, {11'h0, msk, 16'h0005});
		@(posedge I_CLK);
		check(34'(alm), 34'h1);
		check(34'(lat), 34'h0);
		tally_and_finish();
	end
endmodule
